// File: hw/dacv_top.sv
/*
  Verb decoder for the audio function group and its output converter.
  Commands arrive serially on the codec link, pass a two-entry buffer,
  are decoded on the system clock and answered in the next frame.
  Assumes link pins are asynchronous to I_CLK_SYS and much slower.
*/
`timescale 1ns/1ps
// Operation
// - Clock-select write bits choose 96..6 MHz
// - Bit 5 selects 192 MHz clock
// - Clock readback one-hot (zero after reset), upper bits zero
// - Function reset restores widget power-on defaults
// - Configuration defaults survive function reset
// - Function reset leaves link logic alone
// - No status-change request after function reset
// - Decode format, stream select and power verbs
// - Accept status byte writes and combined readback
// - Format word layout; reserved bits read zero
// - Sample size codes; field resets to 011b
// - Channel count in bits 3:0, reset 1h
// - Parameter read answers 09h 0Ah 0Bh 0Fh
// - Widget capability word for output converter
// - Sample sizes 32, 24, 16 supported
// - Rates 32 to 192 kHz supported
// - AC3 and PCM supported, float not
// - Power states D0, D3, extended supported
// - Power readback: actual and echoed request
// - Stream number and lowest channel, reset zero
// - Channel status readback layout, enable resets one
// - Status byte one and category code layout
module dacv_top (
  input wire logic I_CLK_SYS, // System clock, 10 MHz
  input wire logic I_SYS_RST, // Power-on reset, async, active high
  input wire logic I_LINK_RST_N, // Link reset pin, active low
  input wire logic I_LINK_CLK, // Link bit clock pin
  input wire logic I_LINK_SYNC, // Frame sync pin
  input wire logic I_LINK_SDO, // Command bits from host
  output logic O_LINK_SDI, // Response bits to host
  output logic [5:0] O_CLK_SEL, // Selected link clock, one-hot, zero after reset
  output logic O_CONV_ACTIVE, // Converter in D0
  output logic [3:0] O_STREAM_ID, // Link stream of converter
  output logic O_DIGITAL_EN // Digital content enable
);
  // One-hot test used by the clock write; its check uses $onehot0
  function automatic logic is_onehot6(input logic [5:0] v);
    is_onehot6 = (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
  endfunction

  // Fixed capability words by parameter id
  function automatic logic [31:0] param_word(input logic [7:0] id);
    param_word = (id == dacv_pkg::P_AWC) ? dacv_pkg::AWC_VAL :
                 (id == dacv_pkg::P_PSB) ? dacv_pkg::PSB_VAL :
                 (id == dacv_pkg::P_SF) ? dacv_pkg::SF_VAL :
                 (id == dacv_pkg::P_SPS) ? dacv_pkg::SPS_VAL : 32'h0;
  endfunction

  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic lclk_prev_reg;
  dacv_pkg::dacv_lstate_t lstate_reg, lstate_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [31:0] rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
  logic sdi_reg, sdi_next;
  logic hold_v_reg, hold_v_next;
  logic [31:0] hold_reg, hold_next;
  logic [31:0] fifo_mem [0:dacv_pkg::FIFO_DEPTH-1];
  logic wp_reg, rp_reg;
  logic [1:0] cnt_reg, cnt_next;
  logic resp_v_reg, resp_v_next;
  logic [31:0] resp_reg, resp_next;
  logic [5:0] clk_sel_reg, clk_sel_next;
  dacv_pkg::dacv_fmt_t fmt_reg, fmt_next;
  logic [1:0] ps_req_reg, ps_req_next, ps_act_reg, ps_act_next;
  logic [7:0] csid_reg, csid_next;
  dacv_pkg::dacv_dc_t dc_reg, dc_next;

  // Three-stage synchroniser; a lane changes only when stages two and three agree
  assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      filt_reg <= 4'h0;
      lclk_prev_reg <= 1'b0;
    end else begin
      s1_reg <= {I_LINK_RST_N, I_LINK_CLK, I_LINK_SYNC, I_LINK_SDO};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      lclk_prev_reg <= filt_reg[dacv_pkg::LN_CLK];
    end
  end

  // Link-side decodes
  wire link_rst = ~filt_reg[dacv_pkg::LN_RSTN];
  wire lclk_rise = filt_reg[dacv_pkg::LN_CLK] & ~lclk_prev_reg;
  wire l_sync = filt_reg[dacv_pkg::LN_SYNC];
  wire l_data = filt_reg[dacv_pkg::LN_DATA];
  wire frame_start = lclk_rise && l_sync && (lstate_reg == dacv_pkg::LS_IDLE);
  wire bit_done = lclk_rise && !l_sync && (lstate_reg == dacv_pkg::LS_FRAME);
  wire word_done = bit_done && (bit_cnt_reg == dacv_pkg::LAST_BIT);
  wire resp_take = frame_start && resp_v_reg;

  // Frame state; the link reset and the power-on reset clear it, never the function reset
  always_comb begin
    case (lstate_reg)
      dacv_pkg::LS_IDLE: lstate_next = frame_start ? dacv_pkg::LS_FRAME : dacv_pkg::LS_IDLE;
      dacv_pkg::LS_FRAME: lstate_next = word_done ? dacv_pkg::LS_IDLE : dacv_pkg::LS_FRAME;
      default: lstate_next = dacv_pkg::LS_IDLE;
    endcase
  end

  // Shifters: command in on each rise, response out one bit per rise
  assign bit_cnt_next = frame_start ? 5'h00 : bit_done ? 5'(bit_cnt_reg + 5'h01) : bit_cnt_reg;
  assign rx_sh_next = bit_done ? {rx_sh_reg[30:0], l_data} : rx_sh_reg;
  assign tx_sh_next = resp_take ? resp_reg : frame_start ? 32'h0 :
                      bit_done ? {tx_sh_reg[30:0], 1'b0} : tx_sh_reg;
  assign sdi_next = resp_take ? resp_reg[31] : frame_start ? 1'b0 :
                    bit_done ? tx_sh_reg[30] : sdi_reg;
  // A finished word waits here until the buffer has room
  wire fifo_in_ready = (cnt_reg != dacv_pkg::FIFO_FULL);
  wire push = hold_v_reg && fifo_in_ready;
  assign hold_v_next = word_done | (hold_v_reg & ~push);
  assign hold_next = word_done ? {rx_sh_reg[30:0], l_data} : hold_reg;

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lstate_reg <= dacv_pkg::LS_IDLE;
      bit_cnt_reg <= 5'h00;
      rx_sh_reg <= 32'h0;
      tx_sh_reg <= 32'h0;
      sdi_reg <= 1'b0;
      hold_v_reg <= 1'b0;
      hold_reg <= 32'h0;
    end else if (link_rst) begin
      lstate_reg <= dacv_pkg::LS_IDLE;
      bit_cnt_reg <= 5'h00;
      tx_sh_reg <= 32'h0;
      sdi_reg <= 1'b0;
      hold_v_reg <= 1'b0;
    end else begin
      lstate_reg <= lstate_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      sdi_reg <= sdi_next;
      hold_v_reg <= hold_v_next;
      hold_reg <= hold_next;
    end
  end

  // Two-entry buffer; the decoder stalls while an answer waits for its slot
  wire fifo_out_valid = (cnt_reg != 2'h0);
  wire pop = fifo_out_valid && !resp_v_reg;
  assign cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
  always_ff @(posedge I_CLK_SYS) begin
    if (push) begin
      fifo_mem[wp_reg] <= hold_reg;
    end
  end
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (link_rst) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wp_reg <= wp_reg ^ push;
      rp_reg <= rp_reg ^ pop;
      cnt_reg <= cnt_next;
    end
  end

  // Command field decode from the buffer head
  dacv_pkg::dacv_cmd_t head;
  assign head = fifo_mem[rp_reg];
  wire is_fg = (head.nid == dacv_pkg::NID_FG);
  wire is_cv = (head.nid == dacv_pkg::NID_CONV);
  wire [11:0] v12 = head.verb[19:8];
  wire [3:0] v4 = head.verb[19:16];
  wire [7:0] pl = head.verb[7:0];
  wire [15:0] pl16 = head.verb[15:0];
  wire fg_rst = pop && is_fg && (v12 == dacv_pkg::V_FG_RST);
  // Only a single selected frequency is taken; other patterns are ignored
  wire wr_clk = pop && is_fg && (v12 == dacv_pkg::V_SET_CLK) && is_onehot6(pl[5:0]);
  wire wr_fmt = pop && is_cv && (v4 == dacv_pkg::V4_SET_FMT);
  wire wr_ps = pop && is_cv && (v12 == dacv_pkg::V_POWER_STATE_REQUEST);
  wire wr_cs = pop && is_cv && (v12 == dacv_pkg::V_SET_CS);
  wire wr_dc1 = pop && is_cv && (v12 == dacv_pkg::V_CHANNEL_STATUS_BYTE1);
  wire wr_dc2 = pop && is_cv && (v12 == dacv_pkg::V_WRITE_STATUS_BYTE_TWO);
  wire wr_dc3 = pop && is_cv && (v12 == dacv_pkg::V_SET_DC3);
  // Byte four holds nothing: it is accepted, answered with zero and dropped

  // Control next values; payload bits outside each field are dropped
  assign clk_sel_next = fg_rst ? dacv_pkg::CLK_SEL_RST : wr_clk ? pl[5:0] : clk_sel_reg;
  assign fmt_next = fg_rst ? dacv_pkg::FMT_RST :
                    wr_fmt ? {pl16[dacv_pkg::FMT_SBR_POS], pl16[13:11], pl16[10:8],
                              pl16[6:4], pl16[3:0]} : fmt_reg;
  assign ps_req_next = fg_rst ? dacv_pkg::PS_D3 : wr_ps ? pl[1:0] : ps_req_reg;
  // The actual state moves only for the two states the host may ask for
  wire ps_legal = (pl[1:0] == dacv_pkg::PS_D0) || (pl[1:0] == dacv_pkg::PS_D3);
  assign ps_act_next = fg_rst ? dacv_pkg::PS_D3 : (wr_ps && ps_legal) ? pl[1:0] : ps_act_reg;
  assign csid_next = fg_rst ? dacv_pkg::CSID_RST : wr_cs ? pl : csid_reg;
  assign dc_next.b1 = fg_rst ? dacv_pkg::DC1_RST : wr_dc1 ? pl : dc_reg.b1;
  assign dc_next.cc = fg_rst ? dacv_pkg::CC_RST : wr_dc2 ? pl[6:0] : dc_reg.cc;
  assign dc_next.ka = fg_rst ? 1'b0 : wr_dc3 ? pl[dacv_pkg::DC3_KA_POS] : dc_reg.ka;
  assign dc_next.iec_coding_type = fg_rst ? dacv_pkg::ICT_RST : wr_dc3 ? pl[3:0] : dc_reg.iec_coding_type;

  // Response word; sets and unknown verbs answer zero
  wire [31:0] rsp_fmt = {17'h0, fmt_reg.sample_base_rate, fmt_reg.mult, fmt_reg.div, 1'b0,
                         fmt_reg.bits_per_sample, fmt_reg.stream_channel_count};
  wire [31:0] rsp_ps = {26'h0, ps_act_reg, 2'h0, ps_req_reg};
  wire [31:0] rsp_dc = {8'h0, dc_reg.ka, 3'h0, dc_reg.iec_coding_type, 1'b0, dc_reg.cc, dc_reg.b1};
  assign resp_next = (is_fg && v12 == dacv_pkg::V_GET_CLK) ? {26'h0, clk_sel_reg} :
                     !is_cv ? 32'h0 :
                     (v4 == dacv_pkg::V4_GET_FMT) ? rsp_fmt :
                     (v12 == dacv_pkg::V_GET_PARAM) ? param_word(pl) :
                     (v12 == dacv_pkg::V_POWER_STATE_REPORT) ? rsp_ps :
                     (v12 == dacv_pkg::V_GET_CS) ? {24'h0, csid_reg} :
                     (v12 == dacv_pkg::V_CHANNEL_STATUS_READBACK) ? rsp_dc : 32'h0;
  // A new answer wins over the slot taking the old one
  assign resp_v_next = pop | (resp_v_reg & ~resp_take);

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      resp_v_reg <= 1'b0;
      resp_reg <= 32'h0;
    end else if (link_rst) begin
      resp_v_reg <= 1'b0;
    end else begin
      resp_v_reg <= resp_v_next;
      resp_reg <= pop ? resp_next : resp_reg;
    end
  end

  // Function-group state; survives the link reset, the function reset restores it.
  // No configuration-default control lives here, and nothing raises a status change.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      clk_sel_reg <= dacv_pkg::CLK_SEL_RST;
      fmt_reg <= dacv_pkg::FMT_RST;
      ps_req_reg <= dacv_pkg::PS_D3;
      ps_act_reg <= dacv_pkg::PS_D3;
      csid_reg <= dacv_pkg::CSID_RST;
      dc_reg <= '{ka: 1'b0, iec_coding_type: dacv_pkg::ICT_RST, cc: dacv_pkg::CC_RST, b1: dacv_pkg::DC1_RST};
    end else begin
      clk_sel_reg <= clk_sel_next;
      fmt_reg <= fmt_next;
      ps_req_reg <= ps_req_next;
      ps_act_reg <= ps_act_next;
      csid_reg <= csid_next;
      dc_reg <= dc_next;
    end
  end

  // Outputs straight from flip-flops, except O_CONV_ACTIVE, decoded from ps_act_reg
  assign O_LINK_SDI = sdi_reg;
  assign O_CLK_SEL = clk_sel_reg;
  assign O_CONV_ACTIVE = (ps_act_reg == dacv_pkg::PS_D0);
  assign O_STREAM_ID = csid_reg[7:4];
  assign O_DIGITAL_EN = dc_reg.b1[0];

  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  sequence s_get_fmt;
    pop && is_cv && (v4 == dacv_pkg::V4_GET_FMT);
  endsequence
  sequence s_get_param(logic [7:0] id);
    pop && is_cv && (v12 == dacv_pkg::V_GET_PARAM) && (pl == id);
  endsequence
  sequence s_fg_reset;
    fg_rst && !wr_clk;
  endsequence

  AST_CLK_ONEHOT: assert property ($onehot0(clk_sel_reg) && $onehot0(O_CLK_SEL))
    else $error("clock select not one-hot");
  AST_FG_DEFAULTS: assert property (s_fg_reset |=> fmt_reg == dacv_pkg::FMT_RST
    && dc_reg.b1 == dacv_pkg::DC1_RST && ps_act_reg == dacv_pkg::PS_D3 && csid_reg == 8'h00)
    else $error("function reset left a control changed");
  AST_FG_LINK: assert property (s_fg_reset ##0 !lclk_rise && !link_rst
    |=> bit_cnt_reg == $past(bit_cnt_reg) && lstate_reg == $past(lstate_reg))
    else $error("function reset disturbed link logic");
  AST_FMT_READ: assert property (s_get_fmt |=> resp_reg[31:15] == 17'h0
    && !resp_reg[7] && resp_reg[6:4] == $past(fmt_reg.bits_per_sample))
    else $error("format readback malformed");
  AST_SF_PARAM: assert property (s_get_param(dacv_pkg::P_SF) |=> resp_reg == 32'h5)
    else $error("stream format capability wrong");
  AST_PSB_PARAM: assert property (s_get_param(dacv_pkg::P_PSB)
    |=> resp_reg[20:16] == 5'h1a && resp_reg[11:0] == 12'h7f0)
    else $error("size or rate capability wrong");
  AST_PS_D0: assert property (wr_ps && pl[1:0] == 2'h0 |=> ##1 O_CONV_ACTIVE)
    else $error("converter not active after D0 request");
  AST_RESP_HELD: assert property (pop |=> resp_v_reg throughout (!resp_take [*2]))
    else $error("answer lost before its slot");
  AST_NO_STALL_LOSS: assert property (hold_v_reg && !fifo_in_ready && !word_done
    && !link_rst |=> hold_v_reg && $stable(hold_reg))
    else $error("held command dropped under back-pressure");
endmodule

// File: common/dacv_pkg.sv
/*
  Shared constants and types for the display audio converter verb decoder:
  node and verb codes, capability words, reset values, field positions.
  Assumes a single system clock domain; the codec link is sampled, not clocked.
*/
package dacv_pkg;
  // Node addresses
  localparam logic [7:0] NID_FG = 8'h01;
  localparam logic [7:0] NID_CONV = 8'h03;
  // Twelve-bit verbs with an eight-bit payload
  localparam logic [11:0] V_SET_CLK = 12'h724;
  localparam logic [11:0] V_GET_CLK = 12'hf24;
  localparam logic [11:0] V_FG_RST = 12'h7ff;
  localparam logic [11:0] V_GET_PARAM = 12'hf00;
  localparam logic [11:0] V_POWER_STATE_REQUEST = 12'h705;
  localparam logic [11:0] V_POWER_STATE_REPORT = 12'hf05;
  localparam logic [11:0] V_SET_CS = 12'h706;
  localparam logic [11:0] V_GET_CS = 12'hf06;
  localparam logic [11:0] V_CHANNEL_STATUS_READBACK = 12'hf0d;
  localparam logic [11:0] V_CHANNEL_STATUS_BYTE1 = 12'h70d;
  localparam logic [11:0] V_WRITE_STATUS_BYTE_TWO = 12'h70e;
  localparam logic [11:0] V_SET_DC3 = 12'h73e;
  localparam logic [11:0] V_SET_DC4 = 12'h73f;
  // Four-bit verbs with a sixteen-bit payload
  localparam logic [3:0] V4_SET_FMT = 4'h2;
  localparam logic [3:0] V4_GET_FMT = 4'ha;
  // Parameter ids and their fixed answers
  localparam logic [7:0] P_AWC = 8'h09;
  localparam logic [7:0] P_PSB = 8'h0a;
  localparam logic [7:0] P_SF = 8'h0b;
  localparam logic [7:0] P_SPS = 8'h0f;
  localparam logic [31:0] AWC_VAL = 32'h0000_6619;
  localparam logic [31:0] PSB_VAL = 32'h001a_07f0;
  localparam logic [31:0] SF_VAL = 32'h0000_0005;
  localparam logic [31:0] SPS_VAL = 32'h8000_0009;
  // Reset values and power-state codes
  localparam logic [5:0] CLK_SEL_RST = 6'h00;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic [7:0] CSID_RST = 8'h00;
  localparam logic [7:0] DC1_RST = 8'h01;
  localparam logic [6:0] CC_RST = 7'h00;
  localparam logic [3:0] ICT_RST = 4'h0;
  // Field positions inside payloads
  localparam int FMT_SBR_POS = 14;
  localparam int FMT_MULT_POS = 11;
  localparam int FMT_DIV_POS = 8;
  localparam int FMT_BPS_POS = 4;
  localparam int DC3_KA_POS = 7;
  // Link framing and buffering
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // Synchroniser lanes
  localparam int LN_RSTN = 3;
  localparam int LN_CLK = 2;
  localparam int LN_SYNC = 1;
  localparam int LN_DATA = 0;

  typedef struct packed {
    logic [3:0] cad;
    logic [7:0] nid;
    logic [19:0] verb;
  } dacv_cmd_t;

  typedef struct packed {
    logic sample_base_rate;
    logic [2:0] mult;
    logic [2:0] div;
    logic [2:0] bits_per_sample;
    logic [3:0] stream_channel_count;
  } dacv_fmt_t;

  localparam dacv_fmt_t FMT_RST = '{sample_base_rate: 1'b0, mult: 3'h0, div: 3'h0, bits_per_sample: 3'h3, stream_channel_count: 4'h1};

  typedef struct packed {
    logic ka;
    logic [3:0] iec_coding_type;
    logic [6:0] cc;
    logic [7:0] b1;
  } dacv_dc_t;

  typedef enum logic {
    LS_IDLE = 1'b0,
    LS_FRAME = 1'b1
  } dacv_lstate_t;
endpackage

// File: bench/dacv_host_model.sv
/*
  Behavioural host controller for the codec link: sends one command
  word per frame and collects the answer bits seen in that frame.
  Assumes the bench raises i_go and waits for o_done before lowering it.
*/
`timescale 1ns/1ps
module dacv_host_model (
  input wire logic i_go, // Frame request from bench
  input wire logic [31:0] i_cmd, // Command word to send
  output logic o_done, // Frame finished, answer valid
  output logic [31:0] o_resp, // Answer bits seen in this frame
  output logic o_link_clk, // Link bit clock, still outside frames
  output logic o_link_sync, // Frame sync
  output logic o_link_sdo, // Command bits, MSB first
  input wire logic i_link_sdi // Answer bits from the device
);
  localparam int HALF_NS = 400;

  // One frame per request; clock stands still between frames
  initial begin
    o_done = 1'b0;
    o_resp = 32'h0000_0000;
    o_link_clk = 1'b0;
    o_link_sync = 1'b0;
    o_link_sdo = 1'b0;
    forever begin
      wait (i_go === 1'b1);
      #37; // Odd offset keeps link edges off the system clock edges
      o_link_sync = 1'b1;
      #HALF_NS;
      o_link_clk = 1'b1;
      for (int k = 0; k < 32; k++) begin
        #HALF_NS;
        o_link_clk = 1'b0;
        o_link_sync = 1'b0;
        o_link_sdo = i_cmd[31 - k];
        #HALF_NS;
        o_link_clk = 1'b1;
        o_resp[31 - k] = i_link_sdi;
      end
      #HALF_NS;
      o_link_clk = 1'b0;
      o_link_sdo = ~o_link_sdo; // Released line must not keep its last value
      o_done = 1'b1;
      wait (i_go === 1'b0);
      o_done = 1'b0;
    end
  end
endmodule

// File: bench/dacv_top_tb.sv
/*
  Self-checking bench for the converter verb decoder: a table of
  commands with their answers and pin states, then clock codes,
  link reset and power-on reset by hand.
  Assumes the host model in bench/ and the design package.
*/
`timescale 1ns/1ps
module dacv_top_tb;
  localparam int NROW = 31;
  // Command, answer expected in the following frame, pins afterwards
  localparam logic [31:0] ROW_CMD [NROW] = '{
    32'h001f2400, 32'h00172420, 32'h001f2400, 32'h00172403,
    32'h001f2400, 32'h003f0009, 32'h003f000a, 32'h003f000b,
    32'h003f000f, 32'h003f0005, 32'h003f0500, 32'h00370500,
    32'h003f0500, 32'h003a0000, 32'h0032ffff, 32'h003a0000,
    32'h0037065a, 32'h003f0600, 32'h003f0d00, 32'h00370dfe,
    32'h00370eff, 32'h00373eff, 32'h00373fff, 32'h003f0d00,
    32'h005f0500, 32'h0017ff00, 32'h003a0000, 32'h003f0500,
    32'h003f0d00, 32'h003f0600, 32'h001f2400};
  localparam logic [31:0] ROW_ANS [NROW] = '{
    32'h0, 32'h0, 32'h20, 32'h0, 32'h20, 32'h6619, 32'h001a07f0, 32'h5,
    32'h80000009, 32'h0, 32'h33, 32'h0, 32'h0, 32'h31, 32'h0, 32'h7f7f,
    32'h0, 32'h5a, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h008f7ffe,
    32'h0, 32'h0, 32'h31, 32'h33, 32'h1, 32'h0, 32'h0};
  localparam logic [11:0] ROW_OUT [NROW] = '{
    12'h001, 12'h801, 12'h801, 12'h801, 12'h801, 12'h801, 12'h801, 12'h801,
    12'h801, 12'h801, 12'h801, 12'h821, 12'h821, 12'h821, 12'h821, 12'h821,
    12'h82b, 12'h82b, 12'h82b, 12'h82a, 12'h82a, 12'h82a, 12'h82a, 12'h82a,
    12'h82a, 12'h001, 12'h001, 12'h001, 12'h001, 12'h001, 12'h001};

  logic clk_sys;
  logic sys_rst;
  logic link_rst_n;
  logic link_clk;
  logic link_sync;
  logic link_sdo;
  logic link_sdi;
  logic [5:0] clk_sel;
  logic conv_active;
  logic [3:0] stream_id;
  logic digital_en;
  logic host_go;
  logic [31:0] host_cmd;
  logic host_done;
  logic [31:0] host_resp;
  logic [11:0] outs;
  logic [31:0] prev;
  int err_total;
  int cmp_count;

  assign outs = {clk_sel, conv_active, stream_id, digital_en};

  dacv_top dut (
    .I_CLK_SYS(clk_sys), .I_SYS_RST(sys_rst), .I_LINK_RST_N(link_rst_n),
    .I_LINK_CLK(link_clk), .I_LINK_SYNC(link_sync), .I_LINK_SDO(link_sdo),
    .O_LINK_SDI(link_sdi), .O_CLK_SEL(clk_sel), .O_CONV_ACTIVE(conv_active),
    .O_STREAM_ID(stream_id), .O_DIGITAL_EN(digital_en)
  );

  dacv_host_model host (
    .i_go(host_go), .i_cmd(host_cmd), .o_done(host_done), .o_resp(host_resp),
    .o_link_clk(link_clk), .o_link_sync(link_sync), .o_link_sdo(link_sdo),
    .i_link_sdi(link_sdi)
  );

  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One frame; the answer seen belongs to the previous command
  task automatic xfer(input logic [31:0] cmd, input logic [31:0] exp);
    int n;
    host_cmd <= cmd;
    host_go <= 1'b1;
    for (n = 0; n < 600 && host_done !== 1'b1; n++) @(posedge clk_sys);
    if (host_done !== 1'b1) begin
      err_total++;
      test_done();
    end
    host_go <= 1'b0;
    for (n = 0; n < 20 && host_done !== 1'b0; n++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys); // Lets the decoded command reach the pins
    @(negedge clk_sys);
    chk("answer", host_resp, exp);
    @(posedge clk_sys);
  endtask

  initial begin
    sys_rst = 1'b1;
    link_rst_n = 1'b1;
    host_go = 1'b0;
    host_cmd = 32'h0000_0000;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    // Table of ordinary commands, no pending answer before the first
    prev = 32'h0000_0000;
    for (int i = 0; i < NROW; i++) begin
      xfer(ROW_CMD[i], prev);
      chk("pins", {20'h0, outs}, {20'h0, ROW_OUT[i]});
      prev = ROW_ANS[i];
    end
    // Every clock-select code, written then read back
    for (int b = 0; b < 6; b++) begin
      xfer({24'h001724, 8'h01 << b}, prev);
      chk("clock select", {26'h0, clk_sel}, 32'h1 << b);
      xfer(32'h001f2400, 32'h0);
      prev = 32'h1 << b;
    end
    // Link reset drops the pending answer but keeps the controls
    xfer(32'h0037063c, prev);
    xfer(32'h003f0600, 32'h0);
    link_rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    link_rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    xfer(32'h001f2400, 32'h0);
    chk("stream after link reset", {28'h0, stream_id}, 32'h3);
    xfer(32'h003f0500, 32'h20);
    // Power-on reset in mid-run
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pins in reset", {20'h0, outs}, 32'h001);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    xfer(32'h003f0500, 32'h0);
    xfer(32'h001f2400, 32'h33);
    test_done();
  end
endmodule
